// ===== logic/io_channel_regs.vh
// Register offsets, reset values and field positions of the channel I/O map
`ifndef IO_CHANNEL_REGS_VH
`define IO_CHANNEL_REGS_VH

`define ADDR_NULL_OP 7'h00
`define ADDR_FUNC_SEL 7'h01
`define ADDR_CONV_SETUP 7'h05
`define ADDR_LIN_SETUP 7'h09
`define ADDR_GPO_BULK 7'h0d
`define ADDR_GPO_SETUP 7'h0e
`define ADDR_DRIVE_SETUP 7'h12
`define ADDR_LEVEL_CODE 7'h16
`define ADDR_CLEAR_CODE 7'h1a
`define ADDR_LIVE_CODE 7'h1e
`define ADDR_LIN_THRESH 7'h22
`define ADDR_CONV_CTRL 7'h23
`define ADDR_DIAG_SEL 7'h24
`define ADDR_LIN_LEVELS 7'h25
`define ADDR_CONV_RESULT 7'h26
`define ADDR_HEALTH_RESULT 7'h2a
`define ADDR_FAULT_FLAGS 7'h2e
`define ADDR_COND_FLAGS 7'h2f
`define ADDR_FAULT_MASK 7'h3c
`define ADDR_EDGE_COUNT 7'h3d
`define ADDR_READBACK_PTR 7'h41
`define ADDR_OVERTEMP_RST 7'h43
`define ADDR_SW_COMMAND 7'h44
`define ADDR_SPARE 7'h45
`define ADDR_DIE_REV 7'h46

`define RST_ZERO 16'h0000
`define RST_LIN_SETUP 16'h000b
`define RST_FAULT_FLAGS 16'h8000
`define NULL_COMMAND_WORD 16'h0000

`define READBACK_ADDR_MSB 6
`define READBACK_ADDR_LSB 0

`endif

// ===== logic/edge_counter_bank.v
// Four logic-input event counters, one per channel, counting each cycle the event is high
`timescale 1ns/1ns
module edge_counter_bank (
    input wire core_clk,
    input wire rst_n,
    input wire [3:0] input_event,
    output wire [63:0] counts
);
    // One saturating-free wrap counter per channel
    genvar ch;
    generate
        for (ch = 0; ch < 4; ch = ch + 1) begin : g_cnt
            reg [15:0] count;
            always @(posedge core_clk) begin
                if (!rst_n) begin
                    count <= 16'h0000;
                end else if (input_event[ch]) begin
                    count <= count + 16'h0001;
                end
            end
            assign counts[ch*16 +: 16] = count;
        end
    endgenerate
endmodule

// ===== logic/io_channel_register_map.v
// Register bank of the four-channel configurable I/O device
// Contract
// - Zero write to null command changes nothing
// - Null command register stores nothing, reads zero
// - Read-only registers ignore host writes
// - Flag registers readable, cleared by writing ones
// - Command register is write only, reads zero
// - Channel groups take four consecutive addresses
// - Per-channel input event counters, one count per cycle with the event high
// - Live output code register per channel
// - Per-channel converter result registers
// - Four diagnostic result registers
// - Auto read returns the register at the stored readback pointer address
`timescale 1ns/1ns
`include "io_channel_regs.vh"
module io_channel_register_map (
    input wire core_clk,
    input wire rst_n,
    input wire wr_en,
    input wire rd_en,
    input wire [6:0] addr,
    input wire [15:0] wr_data,
    output reg [15:0] rd_data,
    output reg rd_valid,
    input wire frame_end,
    input wire auto_read,
    input wire [63:0] live_code_in,
    input wire [3:0] live_code_load,
    input wire [63:0] result_in,
    input wire [3:0] result_load,
    input wire [63:0] health_in,
    input wire [3:0] health_load,
    input wire [15:0] lin_levels_in,
    input wire [3:0] input_event,
    input wire [15:0] fault_set,
    input wire [15:0] cond_set,
    output wire [255:0] config_out,
    output reg [15:0] command_word,
    output reg command_strobe,
    output wire [15:0] fault_mask_out
);
    parameter [15:0] DIE_REVISION = 16'h0001; // Arbitrary value

    // Per-channel groups, writable and hardware-loaded, each four words wide
    reg [15:0] func_sel [0:3];
    reg [15:0] conv_setup [0:3];
    reg [15:0] lin_setup [0:3];
    reg [15:0] gpo_setup [0:3];
    reg [15:0] drive_setup [0:3];
    reg [15:0] level_code [0:3];
    reg [15:0] clear_code [0:3];
    reg [15:0] live_code [0:3];
    reg [15:0] conv_result [0:3];
    reg [15:0] health_result [0:3];
    reg [15:0] gpo_bulk;
    reg [15:0] lin_thresh;
    reg [15:0] conv_ctrl;
    reg [15:0] diag_sel;
    reg [15:0] lin_levels;
    reg [15:0] fault_flags;
    reg [15:0] cond_flags;
    reg [15:0] fault_mask;
    reg [15:0] readback_ptr;
    reg [15:0] overtemp_rst;
    reg [15:0] spare;
    wire [63:0] edge_counts;
    reg [15:0] next_rd;
    reg hit;
    reg [6:0] rd_addr;
    reg [6:0] rd_rel;
    reg [3:0] grp_sel;
    wire auto_go;
    wire rd_go;
    wire [15:0] rd_word;
    wire [15:0] fault_clr;
    wire [15:0] cond_clr;

    edge_counter_bank u_counters (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .input_event(input_event),
        .counts(edge_counts)
    );

    // Group base plus channel index, low two bits pick A..D
    function in_group;
        input [6:0] a;
        input [6:0] base;
        begin
            in_group = (a >= base) && (a < base + 7'd4);
        end
    endfunction

    // Writable per-channel groups and hardware-loaded read-only words
    genvar ch;
    generate
        for (ch = 0; ch < 4; ch = ch + 1) begin : g_ch
            // Offset from two compares so no wide integer lands in it
            wire [6:0] off = {5'b00000, ch >= 2, ch % 2 == 1};
            always @(posedge core_clk) begin
                if (!rst_n) begin
                    func_sel[ch] <= `RST_ZERO;
                    conv_setup[ch] <= `RST_ZERO;
                    lin_setup[ch] <= `RST_LIN_SETUP;
                    gpo_setup[ch] <= `RST_ZERO;
                    drive_setup[ch] <= `RST_ZERO;
                    level_code[ch] <= `RST_ZERO;
                    clear_code[ch] <= `RST_ZERO;
                    live_code[ch] <= `RST_ZERO;
                    conv_result[ch] <= `RST_ZERO;
                    health_result[ch] <= `RST_ZERO;
                end else begin
                    if (wr_en && addr == `ADDR_FUNC_SEL + off) begin
                        func_sel[ch] <= wr_data;
                    end
                    if (wr_en && addr == `ADDR_CONV_SETUP + off) begin
                        conv_setup[ch] <= wr_data;
                    end
                    if (wr_en && addr == `ADDR_LIN_SETUP + off) begin
                        lin_setup[ch] <= wr_data;
                    end
                    if (wr_en && addr == `ADDR_GPO_SETUP + off) begin
                        gpo_setup[ch] <= wr_data;
                    end
                    if (wr_en && addr == `ADDR_DRIVE_SETUP + off) begin
                        drive_setup[ch] <= wr_data;
                    end
                    if (wr_en && addr == `ADDR_LEVEL_CODE + off) begin
                        level_code[ch] <= wr_data;
                    end
                    if (wr_en && addr == `ADDR_CLEAR_CODE + off) begin
                        clear_code[ch] <= wr_data;
                    end
                    // Only hardware loads these; bus writes have no path
                    if (live_code_load[ch]) begin
                        live_code[ch] <= live_code_in[ch*16 +: 16];
                    end
                    if (result_load[ch]) begin
                        conv_result[ch] <= result_in[ch*16 +: 16];
                    end
                    if (health_load[ch]) begin
                        health_result[ch] <= health_in[ch*16 +: 16];
                    end
                end
            end
            assign config_out[ch*64 +: 16] = func_sel[ch];
            assign config_out[ch*64+16 +: 16] = conv_setup[ch];
            assign config_out[ch*64+32 +: 16] = drive_setup[ch];
            assign config_out[ch*64+48 +: 16] = level_code[ch];
        end
    endgenerate

    // Config words, pointer and spare; holes and read-only words drop out
    always @(posedge core_clk) begin
        if (!rst_n) begin
            gpo_bulk <= `RST_ZERO;
            lin_thresh <= `RST_ZERO;
            conv_ctrl <= `RST_ZERO;
            diag_sel <= `RST_ZERO;
            fault_mask <= `RST_ZERO;
            readback_ptr <= `RST_ZERO;
            overtemp_rst <= `RST_ZERO;
            spare <= `RST_ZERO;
        end else if (wr_en) begin
            case (addr)
                `ADDR_GPO_BULK: gpo_bulk <= wr_data;
                `ADDR_LIN_THRESH: lin_thresh <= wr_data;
                `ADDR_CONV_CTRL: conv_ctrl <= wr_data;
                `ADDR_DIAG_SEL: diag_sel <= wr_data;
                `ADDR_FAULT_MASK: fault_mask <= wr_data;
                `ADDR_READBACK_PTR: readback_ptr <= wr_data;
                `ADDR_OVERTEMP_RST: overtemp_rst <= wr_data;
                `ADDR_SPARE: spare <= wr_data;
                // Null command and holes store nothing; commands go below
                default: ;
            endcase
        end
    end

    // Level snapshot is hardware-owned; the bus has no write path to it
    always @(posedge core_clk) begin
        if (!rst_n) begin
            lin_levels <= `RST_ZERO;
        end else begin
            lin_levels <= lin_levels_in;
        end
    end

    // Host clear masks; a write to any other address clears nothing
    assign fault_clr = (wr_en && addr == `ADDR_FAULT_FLAGS) ?
        wr_data : 16'h0000;
    assign cond_clr = (wr_en && addr == `ADDR_COND_FLAGS) ?
        wr_data : 16'h0000;

    // Event flags: hardware sets them, the host clears by writing ones
    always @(posedge core_clk) begin
        if (!rst_n) begin
            fault_flags <= `RST_FAULT_FLAGS;
            cond_flags <= `RST_ZERO;
        end else begin
            // A new event in the clearing cycle survives: set wins
            fault_flags <= (fault_flags & ~fault_clr) | fault_set;
            cond_flags <= (cond_flags & ~cond_clr) | cond_set;
        end
    end

    // Command word and its one-cycle strobe; the word is never read back
    always @(posedge core_clk) begin
        if (!rst_n) begin
            command_word <= `RST_ZERO;
            command_strobe <= 1'b0;
        end else begin
            command_strobe <= wr_en && addr == `ADDR_SW_COMMAND;
            if (wr_en && addr == `ADDR_SW_COMMAND) begin
                command_word <= wr_data;
            end
        end
    end

    assign fault_mask_out = fault_mask;

    // Read groups, binary coded for the decoder below
    localparam [3:0] GRP_NONE = 4'h0;
    localparam [3:0] GRP_FUNC = 4'h1;
    localparam [3:0] GRP_CONV = 4'h2;
    localparam [3:0] GRP_LIN = 4'h3;
    localparam [3:0] GRP_GPO = 4'h4;
    localparam [3:0] GRP_DRIVE = 4'h5;
    localparam [3:0] GRP_LEVEL = 4'h6;
    localparam [3:0] GRP_CLEAR = 4'h7;
    localparam [3:0] GRP_LIVE = 4'h8;
    localparam [3:0] GRP_RESULT = 4'h9;
    localparam [3:0] GRP_HEALTH = 4'ha;
    localparam [3:0] GRP_EDGE = 4'hb;

    // An auto read at frame end outranks the bus address this cycle
    assign auto_go = auto_read && frame_end;
    assign rd_go = rd_en || auto_go;

    // Address that the read mux decodes this cycle
    always @* begin
        rd_addr = addr;
        if (auto_go) begin
            // Pointer bits above the address field are ignored
            rd_addr = readback_ptr[`READBACK_ADDR_MSB:`READBACK_ADDR_LSB];
        end
    end

    // Group of the read address and the channel inside that group
    always @* begin
        grp_sel = GRP_NONE;
        rd_rel = 7'h00;
        if (in_group(rd_addr, `ADDR_FUNC_SEL)) begin
            grp_sel = GRP_FUNC;
            rd_rel = rd_addr - `ADDR_FUNC_SEL;
        end else if (in_group(rd_addr, `ADDR_CONV_SETUP)) begin
            grp_sel = GRP_CONV;
            rd_rel = rd_addr - `ADDR_CONV_SETUP;
        end else if (in_group(rd_addr, `ADDR_LIN_SETUP)) begin
            grp_sel = GRP_LIN;
            rd_rel = rd_addr - `ADDR_LIN_SETUP;
        end else if (in_group(rd_addr, `ADDR_GPO_SETUP)) begin
            grp_sel = GRP_GPO;
            rd_rel = rd_addr - `ADDR_GPO_SETUP;
        end else if (in_group(rd_addr, `ADDR_DRIVE_SETUP)) begin
            grp_sel = GRP_DRIVE;
            rd_rel = rd_addr - `ADDR_DRIVE_SETUP;
        end else if (in_group(rd_addr, `ADDR_LEVEL_CODE)) begin
            grp_sel = GRP_LEVEL;
            rd_rel = rd_addr - `ADDR_LEVEL_CODE;
        end else if (in_group(rd_addr, `ADDR_CLEAR_CODE)) begin
            grp_sel = GRP_CLEAR;
            rd_rel = rd_addr - `ADDR_CLEAR_CODE;
        end else if (in_group(rd_addr, `ADDR_LIVE_CODE)) begin
            grp_sel = GRP_LIVE;
            rd_rel = rd_addr - `ADDR_LIVE_CODE;
        end else if (in_group(rd_addr, `ADDR_CONV_RESULT)) begin
            grp_sel = GRP_RESULT;
            rd_rel = rd_addr - `ADDR_CONV_RESULT;
        end else if (in_group(rd_addr, `ADDR_HEALTH_RESULT)) begin
            grp_sel = GRP_HEALTH;
            rd_rel = rd_addr - `ADDR_HEALTH_RESULT;
        end else if (in_group(rd_addr, `ADDR_EDGE_COUNT)) begin
            grp_sel = GRP_EDGE;
            rd_rel = rd_addr - `ADDR_EDGE_COUNT;
        end
    end

    // Read mux; only the low two bits of the group offset pick a channel
    always @* begin
        next_rd = 16'h0000;
        hit = 1'b1;
        case (grp_sel)
            GRP_FUNC: next_rd = func_sel[rd_rel[1:0]];
            GRP_CONV: next_rd = conv_setup[rd_rel[1:0]];
            GRP_LIN: next_rd = lin_setup[rd_rel[1:0]];
            GRP_GPO: next_rd = gpo_setup[rd_rel[1:0]];
            GRP_DRIVE: next_rd = drive_setup[rd_rel[1:0]];
            GRP_LEVEL: next_rd = level_code[rd_rel[1:0]];
            GRP_CLEAR: next_rd = clear_code[rd_rel[1:0]];
            GRP_LIVE: next_rd = live_code[rd_rel[1:0]];
            GRP_RESULT: next_rd = conv_result[rd_rel[1:0]];
            GRP_HEALTH: next_rd = health_result[rd_rel[1:0]];
            GRP_EDGE: next_rd = edge_counts[{rd_rel[1:0], 4'h0} +: 16];
            GRP_NONE: begin
                case (rd_addr)
                    `ADDR_NULL_OP: next_rd = 16'h0000;
                    `ADDR_GPO_BULK: next_rd = gpo_bulk;
                    `ADDR_LIN_THRESH: next_rd = lin_thresh;
                    `ADDR_CONV_CTRL: next_rd = conv_ctrl;
                    `ADDR_DIAG_SEL: next_rd = diag_sel;
                    `ADDR_LIN_LEVELS: next_rd = lin_levels;
                    `ADDR_FAULT_FLAGS: next_rd = fault_flags;
                    `ADDR_COND_FLAGS: next_rd = cond_flags;
                    `ADDR_FAULT_MASK: next_rd = fault_mask;
                    `ADDR_READBACK_PTR: next_rd = readback_ptr;
                    `ADDR_OVERTEMP_RST: next_rd = overtemp_rst;
                    `ADDR_SW_COMMAND: next_rd = 16'h0000;
                    `ADDR_SPARE: next_rd = spare;
                    `ADDR_DIE_REV: next_rd = DIE_REVISION;
                    default: hit = 1'b0;
                endcase
            end
            default: hit = 1'b0;
        endcase
    end

    // Hole reads answer zero rather than the last decoded word
    assign rd_word = hit ? next_rd : 16'h0000;

    // Read data holds until the next read is taken
    always @(posedge core_clk) begin
        if (!rst_n) begin
            rd_data <= 16'h0000;
        end else if (rd_go) begin
            rd_data <= rd_word;
        end
    end

    // Answer strobe, one cycle after each taken read
    always @(posedge core_clk) begin
        if (!rst_n) begin
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= rd_go;
        end
    end
endmodule

// ===== tb/io_channel_register_map_props.sv
// Port-level checks of the channel I/O register map
`timescale 1ns/1ns
module reg_map_props (
    input wire core_clk,
    input wire rst_n,
    input wire wr_en,
    input wire rd_en,
    input wire [6:0] addr,
    input wire [15:0] wr_data,
    input wire [15:0] rd_data,
    input wire rd_valid,
    input wire frame_end,
    input wire auto_read,
    input wire [255:0] config_out,
    input wire [15:0] command_word,
    input wire command_strobe,
    input wire [15:0] fault_mask_out
);
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    // Plain reads only; an auto read takes over the read mux
    wire auto_go = frame_end && auto_read;
    wire plain_rd = rd_en && !auto_go;
    wire hole = (addr > 7'h2f && addr < 7'h3c) || addr == 7'h42
        || addr > 7'h46;
    a_answer_pulse: assert property (
        rd_valid == $past(rd_en || auto_go)) else $error("bad rd_valid");
    a_null_reads_zero: assert property (
        plain_rd && addr == 7'h00 |=> rd_data == 16'h0000)
        else $error("null register not zero");
    a_command_reads_zero: assert property (
        plain_rd && addr == 7'h44 |=> rd_data == 16'h0000)
        else $error("command register readable");
    a_hole_reads_zero: assert property (
        plain_rd && hole |=> rd_data == 16'h0000) else $error("hole not zero");
    a_command_strobe: assert property (
        command_strobe == $past(wr_en && addr == 7'h44))
        else $error("bad command strobe");
    a_command_word: assert property (
        wr_en && addr == 7'h44 |=> command_word == $past(wr_data))
        else $error("bad command word");
    a_null_no_effect: assert property (
        wr_en && addr == 7'h00 |=> $stable(config_out)
        && $stable(fault_mask_out) && !command_strobe)
        else $error("null write changed state");
    a_ro_ignored: assert property (
        wr_en && addr >= 7'h1e && addr <= 7'h21 |=> $stable(config_out))
        else $error("read-only write changed state");
    a_group_last: assert property (
        wr_en && addr == 7'h04 |=> config_out[207:192] == $past(wr_data))
        else $error("channel D function misplaced");
    a_level_first: assert property (
        wr_en && addr == 7'h16 |=> config_out[63:48] == $past(wr_data))
        else $error("channel A level misplaced");
endmodule
bind io_channel_register_map reg_map_props props_u (.core_clk(core_clk),
    .rst_n(rst_n), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
    .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid),
    .frame_end(frame_end), .auto_read(auto_read), .config_out(config_out),
    .command_word(command_word), .command_strobe(command_strobe),
    .fault_mask_out(fault_mask_out));

// ===== tb/host_bus.sv
// Host controller model issuing register reads and writes
`timescale 1ns/1ns
module host_bus (
    input wire core_clk,
    input wire [15:0] rd_data,
    input wire rd_valid,
    output reg wr_en = 1'b0,
    output reg rd_en = 1'b0,
    output reg [6:0] addr = 7'h00,
    output reg [15:0] wr_data = 16'h0000
);
    // Held to the taking edge; released lines are scrambled so stale
    // values never look valid
    task wr(input [6:0] a, input [15:0] d);
        begin
            @(posedge core_clk);
            wr_en <= 1'b1;
            addr <= a;
            wr_data <= d;
            @(posedge core_clk);
            wr_en <= 1'b0;
            addr <= ~a;
            wr_data <= ~d;
        end
    endtask
    // Answer registered at the taking edge, picked up once it settles
    task rd(input [6:0] a, output [15:0] d, output v);
        begin
            @(posedge core_clk);
            rd_en <= 1'b1;
            addr <= a;
            @(posedge core_clk);
            rd_en <= 1'b0;
            addr <= ~a;
            #1;
            d = rd_data;
            v = rd_valid;
        end
    endtask
endmodule

// ===== tb/io_channel_register_map_test.sv
// Self-checking bench for the channel I/O register map
`timescale 1ns/1ns
module io_channel_register_map_test;
    reg core_clk = 1'b0, rst_n = 1'b0, frame_end = 1'b0, auto_read = 1'b0;
    reg [63:0] live_code_in = 64'h0, result_in = 64'h0, health_in = 64'h0;
    reg [3:0] live_code_load = 4'h0, result_load = 4'h0;
    reg [3:0] health_load = 4'h0, input_event = 4'h0;
    reg [15:0] lin_levels_in = 16'h5a5a, fault_set = 16'h0, cond_set = 16'h0;
    wire wr_en, rd_en, rd_valid, command_strobe;
    wire [6:0] addr;
    wire [15:0] wr_data, rd_data, command_word, fault_mask_out;
    wire [255:0] config_out;
    integer bad_count = 0, comparisons = 0, i;
    reg [15:0] got;
    reg vld;
    always #5 core_clk = ~core_clk;
    host_bus host_u (.core_clk(core_clk), .rd_data(rd_data),
        .rd_valid(rd_valid), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
        .wr_data(wr_data));
    io_channel_register_map dut_u (.core_clk(core_clk), .rst_n(rst_n),
        .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wr_data(wr_data),
        .rd_data(rd_data), .rd_valid(rd_valid), .frame_end(frame_end),
        .auto_read(auto_read), .live_code_in(live_code_in),
        .live_code_load(live_code_load), .result_in(result_in),
        .result_load(result_load), .health_in(health_in),
        .health_load(health_load), .lin_levels_in(lin_levels_in),
        .input_event(input_event), .fault_set(fault_set),
        .cond_set(cond_set), .config_out(config_out),
        .command_word(command_word), .command_strobe(command_strobe),
        .fault_mask_out(fault_mask_out));
    task check(input [15:0] seen, input [15:0] want);
        begin
            comparisons = comparisons + 1;
            if (seen !== want) begin
                bad_count = bad_count + 1;
                $display("mismatch at %0t: got %h want %h", $time, seen, want);
            end
        end
    endtask
    task rd_check(input [6:0] a, input [15:0] want);
        begin
            host_u.rd(a, got, vld);
            check({15'h0, vld}, 16'h0001);
            check(got, want);
        end
    endtask
    task reset_values;
        begin
            rd_check(7'h09, 16'h000b);
            rd_check(7'h0c, 16'h000b);
            rd_check(7'h2e, 16'h8000);
            rd_check(7'h46, 16'h0001);
            rd_check(7'h25, 16'h5a5a);
        end
    endtask
    task groups_and_null;
        begin
            for (i = 0; i < 4; i = i + 1) begin
                host_u.wr(7'h01 + i[6:0], 16'h1100 + i[15:0]);
                host_u.wr(7'h16 + i[6:0], 16'h2200 + i[15:0]);
            end
            host_u.wr(7'h3c, 16'h00f0);
            host_u.wr(7'h00, 16'h0000);
            host_u.wr(7'h00, 16'h1234);
            rd_check(7'h00, 16'h0000);
            check(fault_mask_out, 16'h00f0);
            for (i = 0; i < 4; i = i + 1) begin
                rd_check(7'h01 + i[6:0], 16'h1100 + i[15:0]);
                check(config_out[64*i +: 16], 16'h1100 + i[15:0]);
                check(config_out[64*i+48 +: 16], 16'h2200 + i[15:0]);
            end
        end
    endtask
    // Live values are loaded, then host writes over live codes and results must not stick
    task live_values;
        begin
            @(posedge core_clk);
            live_code_in <= 64'h0d0d_0c0c_0b0b_0a0a;
            result_in <= 64'h4444_3333_2222_1111;
            health_in <= 64'h8888_7777_6666_5555;
            {live_code_load, result_load, health_load} <= 12'hfff;
            @(posedge core_clk);
            {live_code_load, result_load, health_load} <= 12'h000;
            for (i = 0; i < 4; i = i + 1) begin
                host_u.wr(7'h1e + i[6:0], 16'hffff);
                host_u.wr(7'h26 + i[6:0], 16'hffff);
                rd_check(7'h1e + i[6:0], live_code_in[16*i +: 16]);
                rd_check(7'h26 + i[6:0], result_in[16*i +: 16]);
                rd_check(7'h2a + i[6:0], health_in[16*i +: 16]);
            end
        end
    endtask
    // Channel n sees n+1 events
    task counters;
        begin
            for (i = 0; i < 4; i = i + 1) repeat (i + 1) begin
                @(posedge core_clk);
                input_event <= 4'h1 << i;
                @(posedge core_clk);
                input_event <= 4'h0;
            end
            host_u.wr(7'h3d, 16'h0077);
            for (i = 0; i < 4; i = i + 1)
                rd_check(7'h3d + i[6:0], i[15:0] + 16'h1);
        end
    endtask
    task flags_command_holes;
        begin
            @(posedge core_clk);
            fault_set <= 16'h0009;
            cond_set <= 16'h0120;
            @(posedge core_clk);
            fault_set <= 16'h0;
            cond_set <= 16'h0;
            rd_check(7'h2e, 16'h8009);
            rd_check(7'h2f, 16'h0120);
            host_u.wr(7'h2e, 16'h0001);
            host_u.wr(7'h2f, 16'hffff);
            rd_check(7'h2e, 16'h8008);
            rd_check(7'h2f, 16'h0000);
            // Clear and a new event on one bit in the same cycle: set wins
            fork
                host_u.wr(7'h2e, 16'h8008);
                begin
                    @(posedge core_clk);
                    fault_set <= 16'h0008;
                    @(posedge core_clk);
                    fault_set <= 16'h0000;
                end
            join
            rd_check(7'h2e, 16'h0008);
            host_u.wr(7'h44, 16'h5a01);
            #1;
            check(command_word, 16'h5a01);
            check({15'h0, command_strobe}, 16'h0001);
            rd_check(7'h44, 16'h0000);
            host_u.wr(7'h30, 16'hffff);
            host_u.wr(7'h42, 16'hffff);
            rd_check(7'h30, 16'h0000);
            rd_check(7'h42, 16'h0000);
            rd_check(7'h50, 16'h0000);
        end
    endtask
    // Frame end with auto read on returns the pointed register
    task auto_readback;
        begin
            host_u.wr(7'h45, 16'hbeef);
            host_u.wr(7'h41, 16'h0045);
            @(posedge core_clk);
            {frame_end, auto_read} <= 2'b11;
            @(posedge core_clk);
            {frame_end, auto_read} <= 2'b00;
            #1;
            check(rd_data, 16'hbeef);
            check({15'h0, rd_valid}, 16'h0001);
        end
    endtask
    task results;
        begin
            if (bad_count == 0 && comparisons > 0) begin
                $display("Testbench passed");
            end else begin
                $display("Testbench failed");
            end
            $finish;
        end
    endtask
    initial begin
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        reset_values;
        groups_and_null;
        live_values;
        counters;
        flags_command_holes;
        auto_readback;
        results;
    end
    // Whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge core_clk);
        bad_count = bad_count + 1;
        results;
    end
endmodule
